// ---- logic/asp_pkg.sv ----
package asp_pkg;
   // register map: nonvolatile words at printed offsets, mirrors 0x40 higher
   localparam logic [6:0] ADDR_STATUS = 7'h00;
   localparam logic [6:0] ADDR_FIRST = 7'h17;
   localparam logic [6:0] ADDR_LAST = 7'h34;
   localparam logic [6:0] MIRROR_DELTA = 7'h40;
   localparam int NUM_WORDS = 30;
   localparam logic [6:0] ADDR_A_POL_OFFS = 7'h17;
   localparam logic [6:0] ADDR_A_OFFS_SLOPE = 7'h18;
   localparam logic [6:0] ADDR_A_SENS = 7'h19;
   localparam logic [6:0] ADDR_A_SENS_TC1 = 7'h1a;
   localparam logic [6:0] ADDR_A_SENS_TC2 = 7'h1b;
   localparam logic [6:0] ADDR_B_POL_OFFS = 7'h1c;
   localparam logic [6:0] ADDR_B_OFFS_SLOPE = 7'h1d;
   localparam logic [6:0] ADDR_B_SENS = 7'h1e;
   localparam logic [6:0] ADDR_B_SENS_TC1 = 7'h1f;
   localparam logic [6:0] ADDR_TEMP_B_TC2 = 7'h20;
   localparam logic [6:0] ADDR_LIN_CTRL = 7'h21;
   localparam logic [6:0] ADDR_COEF_PAIR1 = 7'h22;
   localparam logic [6:0] ADDR_ANGLE_CTRL = 7'h32;
   localparam logic [6:0] ADDR_HYST_GAIN = 7'h33;
   localparam logic [6:0] ADDR_POST_LIMIT = 7'h34;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   // field positions
   localparam int ECC_MSB = 31;
   localparam int ECC_LSB = 26;
   localparam int POL_BIT = 14;
   localparam int OFFS_MSB = 13;
   localparam int HOT_OFFS_MSB = 23;
   localparam int HOT_OFFS_LSB = 12;
   localparam int COLD_OFFS_MSB = 11;
   localparam int SENS_MSB = 13;
   localparam int A_TC1_HOT_MSB = 21;
   localparam int A_TC1_HOT_LSB = 11;
   localparam int A_TC1_COLD_MSB = 10;
   localparam int A_TC2_HOT_MSB = 19;
   localparam int A_TC2_HOT_LSB = 10;
   localparam int A_TC2_COLD_MSB = 9;
   localparam int B_TC1_HOT_MSB = 19;
   localparam int B_TC1_HOT_LSB = 10;
   localparam int B_TC1_COLD_MSB = 9;
   localparam int B_TC2_HOT_MSB = 21;
   localparam int B_TC2_HOT_LSB = 11;
   localparam int B_TC2_COLD_MSB = 10;
   localparam int TEMP_TRIM_MSB = 24;
   localparam int TEMP_TRIM_LSB = 20;
   localparam int COEF_HI_MSB = 25;
   localparam int COEF_HI_LSB = 13;
   localparam int COEF_LO_MSB = 12;
   localparam int LIN_ACTIVE_MSB = 9;
   localparam int LIN_ACTIVE_LSB = 5;
   localparam int LIN_SCALAR_MSB = 4;
   localparam int LIN_SCALAR_LSB = 3;
   localparam int LIN_SEL_MSB = 2;
   localparam int LIN_SEL_LSB = 1;
   localparam int LIN_EN_BIT = 0;
   localparam int PRE_OFFS_MSB = 17;
   localparam int PRE_OFFS_LSB = 3;
   localparam int BYPASS_BIT = 2;
   localparam int ORDER_BIT = 1;
   localparam int ANGLE_INV_BIT = 0;
   localparam int HYST_MSB = 22;
   localparam int HYST_LSB = 16;
   localparam int GAIN_MSB = 15;
   localparam int ROLL_MSB = 25;
   localparam int ROLL_LSB = 18;
   localparam int SAT_SEL_BIT = 17;
   localparam int POST_OFFS_MSB = 16;
   localparam int POST_OFFS_LSB = 1;
   localparam int LIMIT_EN_BIT = 0;
   // arithmetic scaling
   localparam int TRIM_FRAC = 14;
   localparam logic signed [31:0] TRIM_UNITY = 32'sh0000_4000;
   localparam int TC1_SHIFT = 8;
   localparam int TC2_SHIFT = 16;
   localparam int GAIN_FRAC = 12;
   localparam logic [15:0] BYPASS_BIAS = 16'h8000;
   localparam logic [15:0] HALF_TURN = 16'h8000;
   localparam logic signed [15:0] ROOM_TEMP = 16'sh0032;
   localparam int CORDIC_STEPS = 14;
   localparam int SEG_BITS = 11;
   localparam int BIN_OUT_SHIFT = 3;
   localparam logic [1:0] LIN_PIECEWISE = 2'h0;
   localparam logic [1:0] LIN_BINNING = 2'h1;

   typedef struct packed {
      logic signed [15:0] first;
      logic signed [15:0] second;
   } asp_chan_pair_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TRIM = 3'b001,
      ST_ROT = 3'b010,
      ST_SHORT = 3'b011,
      ST_LIN = 3'b100
   } asp_state_t;
endpackage : asp_pkg

// ---- logic/asp_signal_path.sv ----
`timescale 1ns/1ps
// Behaviour
// R01: first channel invert bit negates its sample
// R02: second channel invert bit negates its sample
// R03: 14-bit room offset corrects each channel
// R04: hot and cold offset slopes per channel
// R05: 14-bit room gain trim scales each channel
// R06: linear and quadratic gain slopes, hot/cold
// R07: 5-bit signed half-degree trim added to temperature
// R08: linearization off ignores all its settings
// R09: two 13-bit coefficients per word, high upper
// R10: active coefficient count and coefficient scaling
// R11: select field picks linearization function
// R12: binning mode applies 7-bit boundary hysteresis
// R13: no bypass computes atan2 in chosen order
// R14: bypass passes chosen channel plus 32768
// R15: angle invert bit negates angle stage output
// R16: signed 15-bit offset added before gain
// R17: angle multiplied by 16-bit gain
// R18: 16-bit offset added after gain
// R19: 8-bit rollover point sets the limit
// R20: rollover mode wraps past limit to zero
// R21: saturate mode clamps high or low
// R22: spare bits stored only, no effect
// R23: mirror 0x40 higher, loaded at power-up and writes
// R24: top six check bits replaced on writes
// R25: limiting off passes gain and offset result
// R26: offset, gain, offset, then limit, fixed order
module asp_signal_path (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [6:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire asp_pkg::asp_chan_pair_t sampleIn,
   input wire logic signed [15:0] tempIn,
   input wire logic sampleValid,
   output logic sampleReady,
   output logic [15:0] angleOut,
   output logic angleValid,
   output logic signed [15:0] tempOut,
   output logic loadBusy
);
   localparam int NUM_WORDS = asp_pkg::NUM_WORDS;

   logic [31:0] nvMem [NUM_WORDS];
   logic [31:0] mirMem [NUM_WORDS];
   asp_pkg::asp_state_t state_q;
   logic [4:0] loadIdx_q;
   logic [3:0] step_q;
   asp_pkg::asp_chan_pair_t trim_q;
   logic signed [15:0] temp_q;
   logic signed [17:0] cx_q, cy_q;
   logic [15:0] cz_q;
   logic [15:0] short_q;
   logic [5:0] binHeld_q;

   // field extraction with sign or zero extension to 16 bits
   function automatic logic signed [15:0] sx(input logic [31:0] w, input int msb, input int lsb);
      logic signed [31:0] t;
      t = signed'(w << (31 - msb));
      return 16'(t >>> (31 - msb + lsb));
   endfunction : sx

   function automatic logic [15:0] ux(input logic [31:0] w, input int msb, input int lsb);
      logic [31:0] t;
      t = w << (31 - msb);
      return 16'(t >> (31 - msb + lsb));
   endfunction : ux

   // internal check bits over the 26 payload bits
   function automatic logic [5:0] checkBits(input logic [31:0] w);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i <= asp_pkg::ECC_LSB - 1; i++) begin
         for (int k = 0; k < 5; k++) begin
            if (((i + 1) >> k) % 2 == 1) begin
               c[k] = c[k] ^ w[i];
            end
         end
         c[5] = c[5] ^ w[i];
      end
      c[5] = c[5] ^ (^c[4:0]);
      return c;
   endfunction : checkBits

   function automatic logic [4:0] wordIdx(input logic [6:0] a);
      return 5'(a - asp_pkg::ADDR_FIRST);
   endfunction : wordIdx

   // arctangent table in 1/65536 turn
   function automatic logic [15:0] atanStep(input logic [3:0] i);
      unique case (i)
         4'h0: return 16'h2000;
         4'h1: return 16'h12e4;
         4'h2: return 16'h09fb;
         4'h3: return 16'h0511;
         4'h4: return 16'h028b;
         4'h5: return 16'h0146;
         4'h6: return 16'h00a3;
         4'h7: return 16'h0051;
         4'h8: return 16'h0029;
         4'h9: return 16'h0014;
         4'ha: return 16'h000a;
         4'hb: return 16'h0005;
         4'hc: return 16'h0003;
         default: return 16'h0001;
      endcase
   endfunction : atanStep

   // one channel's temperature-aware offset and gain correction
   function automatic logic signed [15:0] trimChan(input logic signed [15:0] raw,
         input logic inv, input logic signed [15:0] offs, input logic signed [15:0] oHot,
         input logic signed [15:0] oCold, input logic signed [15:0] sens,
         input logic signed [15:0] g1Hot, input logic signed [15:0] g1Cold,
         input logic signed [15:0] g2Hot, input logic signed [15:0] g2Cold,
         input logic signed [15:0] dT);
      logic hot;
      logic signed [31:0] x, o, g, d2, p;
      hot = (dT > 16'sh0000);
      x = inv ? -32'(raw) : 32'(raw); // R01 R02
      o = 32'(offs) + ((32'(hot ? oHot : oCold) * 32'(dT)) >>> asp_pkg::TC1_SHIFT); // R03 R04
      d2 = 32'(dT) * 32'(dT);
      g = asp_pkg::TRIM_UNITY + 32'(sens) // R05
         + ((32'(hot ? g1Hot : g1Cold) * 32'(dT)) >>> asp_pkg::TC1_SHIFT) // R06
         + ((32'(hot ? g2Hot : g2Cold) * d2) >>> asp_pkg::TC2_SHIFT); // R06
      p = (x - o) * g;
      return 16'(p >>> asp_pkg::TRIM_FRAC);
   endfunction : trimChan

   // configuration views taken from the mirrors, which alone steer the path
   logic [31:0] wAPol, wASlope, wASens, wATc1, wATc2, wBPol, wBSlope, wBSens, wBTc1, wTempB;
   logic [31:0] wLin, wAng, wHyst, wPost;
   assign wAPol = mirMem[wordIdx(asp_pkg::ADDR_A_POL_OFFS)];
   assign wASlope = mirMem[wordIdx(asp_pkg::ADDR_A_OFFS_SLOPE)];
   assign wASens = mirMem[wordIdx(asp_pkg::ADDR_A_SENS)];
   assign wATc1 = mirMem[wordIdx(asp_pkg::ADDR_A_SENS_TC1)];
   assign wATc2 = mirMem[wordIdx(asp_pkg::ADDR_A_SENS_TC2)];
   assign wBPol = mirMem[wordIdx(asp_pkg::ADDR_B_POL_OFFS)];
   assign wBSlope = mirMem[wordIdx(asp_pkg::ADDR_B_OFFS_SLOPE)];
   assign wBSens = mirMem[wordIdx(asp_pkg::ADDR_B_SENS)];
   assign wBTc1 = mirMem[wordIdx(asp_pkg::ADDR_B_SENS_TC1)];
   assign wTempB = mirMem[wordIdx(asp_pkg::ADDR_TEMP_B_TC2)];
   assign wLin = mirMem[wordIdx(asp_pkg::ADDR_LIN_CTRL)];
   assign wAng = mirMem[wordIdx(asp_pkg::ADDR_ANGLE_CTRL)];
   assign wHyst = mirMem[wordIdx(asp_pkg::ADDR_HYST_GAIN)];
   assign wPost = mirMem[wordIdx(asp_pkg::ADDR_POST_LIMIT)];

   // coefficient n: 0 sits high in the control word, then low/high pairs
   function automatic logic signed [15:0] coefAt(input logic [5:0] n, input logic [4:0] act);
      logic [31:0] w;
      w = mirMem[wordIdx(asp_pkg::ADDR_LIN_CTRL) + 5'((n + 6'h01) >> 1)];
      if (n >= {1'b0, act}) begin // R10
         return 16'sh0000;
      end
      if (n[0]) begin
         return sx(w, asp_pkg::COEF_LO_MSB, 0); // R09
      end
      return sx(w, asp_pkg::COEF_HI_MSB, asp_pkg::COEF_HI_LSB); // R09
   endfunction : coefAt

   // register writes: stored word gets fresh check bits; nv writes refresh the mirror
   logic nvHit, mirHit, stHit;
   logic [31:0] wrWord;
   assign nvHit = regAddr >= asp_pkg::ADDR_FIRST && regAddr <= asp_pkg::ADDR_LAST;
   assign mirHit = regAddr >= asp_pkg::ADDR_FIRST + asp_pkg::MIRROR_DELTA
      && regAddr <= asp_pkg::ADDR_LAST + asp_pkg::MIRROR_DELTA;
   assign stHit = regAddr == asp_pkg::ADDR_STATUS;
   assign wrWord = {checkBits(regWdata), regWdata[asp_pkg::ECC_LSB-1:0]}; // R24

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            nvMem[i] <= asp_pkg::WORD_RESET;
         end
      end else if (regWr && nvHit) begin
         nvMem[wordIdx(regAddr)] <= wrWord; // R22
      end
   end

   // mirror copy walks all words after reset; bus writes win over the walk
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_WORDS; i++) begin
            mirMem[i] <= asp_pkg::WORD_RESET;
         end
      end else begin
         if (loadBusy) begin
            mirMem[loadIdx_q] <= nvMem[loadIdx_q]; // R23
         end
         if (regWr && nvHit) begin
            mirMem[wordIdx(regAddr)] <= wrWord; // R23
         end else if (regWr && mirHit) begin
            mirMem[wordIdx(regAddr - asp_pkg::MIRROR_DELTA)] <= wrWord; // R23
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         loadIdx_q <= 5'h00;
         loadBusy <= 1'b1;
      end else if (loadBusy) begin
         loadIdx_q <= 5'(loadIdx_q + 5'h01);
         loadBusy <= loadIdx_q != 5'(NUM_WORDS - 1);
      end
   end

   // read data stand one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 32'h0000_0000;
      end else if (regRd && nvHit) begin
         regRdata <= nvMem[wordIdx(regAddr)];
      end else if (regRd && mirHit) begin
         regRdata <= mirMem[wordIdx(regAddr - asp_pkg::MIRROR_DELTA)];
      end else if (regRd && stHit) begin
         regRdata <= {11'h000, binHeld_q[4:0], angleOut};
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end

   // sequencer: samples are refused while a conversion or the mirror load runs
   assign sampleReady = state_q == asp_pkg::ST_IDLE && !loadBusy;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= asp_pkg::ST_IDLE;
         step_q <= 4'h0;
      end else begin
         unique case (state_q)
            asp_pkg::ST_IDLE: begin
               if (sampleValid && sampleReady) begin
                  state_q <= asp_pkg::ST_TRIM;
               end
            end
            asp_pkg::ST_TRIM: begin
               step_q <= 4'h0;
               state_q <= wAng[asp_pkg::BYPASS_BIT] ? asp_pkg::ST_SHORT : asp_pkg::ST_ROT; // R14
            end
            asp_pkg::ST_ROT: begin
               step_q <= 4'(step_q + 4'h1);
               if (step_q == 4'(asp_pkg::CORDIC_STEPS - 1)) begin
                  state_q <= asp_pkg::ST_SHORT;
               end
            end
            asp_pkg::ST_SHORT: state_q <= asp_pkg::ST_LIN; // R26
            asp_pkg::ST_LIN: state_q <= asp_pkg::ST_IDLE;
            default: state_q <= asp_pkg::ST_IDLE;
         endcase
      end
   end

   // channel trims and temperature report, taken with the sample
   logic signed [15:0] dT;
   assign dT = 16'(tempIn - asp_pkg::ROOM_TEMP);
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         trim_q <= '0;
         temp_q <= 16'sh0000;
         tempOut <= 16'sh0000;
      end else if (sampleValid && sampleReady) begin
         trim_q.first <= trimChan(sampleIn.first, wAPol[asp_pkg::POL_BIT],
            sx(wAPol, asp_pkg::OFFS_MSB, 0),
            sx(wASlope, asp_pkg::HOT_OFFS_MSB, asp_pkg::HOT_OFFS_LSB),
            sx(wASlope, asp_pkg::COLD_OFFS_MSB, 0), sx(wASens, asp_pkg::SENS_MSB, 0),
            sx(wATc1, asp_pkg::A_TC1_HOT_MSB, asp_pkg::A_TC1_HOT_LSB),
            sx(wATc1, asp_pkg::A_TC1_COLD_MSB, 0),
            sx(wATc2, asp_pkg::A_TC2_HOT_MSB, asp_pkg::A_TC2_HOT_LSB),
            sx(wATc2, asp_pkg::A_TC2_COLD_MSB, 0), dT);
         trim_q.second <= trimChan(sampleIn.second, wBPol[asp_pkg::POL_BIT],
            sx(wBPol, asp_pkg::OFFS_MSB, 0),
            sx(wBSlope, asp_pkg::HOT_OFFS_MSB, asp_pkg::HOT_OFFS_LSB),
            sx(wBSlope, asp_pkg::COLD_OFFS_MSB, 0), sx(wBSens, asp_pkg::SENS_MSB, 0),
            sx(wBTc1, asp_pkg::B_TC1_HOT_MSB, asp_pkg::B_TC1_HOT_LSB),
            sx(wBTc1, asp_pkg::B_TC1_COLD_MSB, 0),
            sx(wTempB, asp_pkg::B_TC2_HOT_MSB, asp_pkg::B_TC2_HOT_LSB),
            sx(wTempB, asp_pkg::B_TC2_COLD_MSB, 0), dT);
         tempOut <= 16'(tempIn + sx(wTempB, asp_pkg::TEMP_TRIM_MSB,
            asp_pkg::TEMP_TRIM_LSB)); // R07
      end
   end

   // vectoring cordic: y is the numerator, x the denominator
   logic signed [17:0] num, den;
   logic order;
   assign order = wAng[asp_pkg::ORDER_BIT];
   assign num = order ? 18'(trim_q.second) : 18'(trim_q.first); // R13
   assign den = order ? 18'(trim_q.first) : 18'(trim_q.second); // R13
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cx_q <= 18'sh00000;
         cy_q <= 18'sh00000;
         cz_q <= 16'h0000;
      end else if (state_q == asp_pkg::ST_TRIM) begin
         // left half plane is folded by a half turn so the steps converge
         cx_q <= den[17] ? -den : den;
         cy_q <= den[17] ? -num : num;
         cz_q <= den[17] ? asp_pkg::HALF_TURN : 16'h0000;
      end else if (state_q == asp_pkg::ST_ROT) begin
         if (cy_q[17]) begin
            cx_q <= cx_q - (cy_q >>> step_q);
            cy_q <= cy_q + (cx_q >>> step_q);
            cz_q <= 16'(cz_q - atanStep(step_q));
         end else begin
            cx_q <= cx_q + (cy_q >>> step_q);
            cy_q <= cy_q - (cx_q >>> step_q);
            cz_q <= 16'(cz_q + atanStep(step_q));
         end
      end
   end

   // angle stage output, then the short-stroke chain
   logic [15:0] angleRaw, angleStage;
   logic signed [31:0] preGain, gained, postGain, limitVal;
   assign angleRaw = wAng[asp_pkg::BYPASS_BIT]
      ? 16'((order ? trim_q.second : trim_q.first) + asp_pkg::BYPASS_BIAS) // R14
      : cz_q;
   assign angleStage = wAng[asp_pkg::ANGLE_INV_BIT] ? 16'(-angleRaw) : angleRaw; // R15
   assign preGain = 32'(angleStage) + 32'(sx(wAng, asp_pkg::PRE_OFFS_MSB,
      asp_pkg::PRE_OFFS_LSB)); // R16
   // signed product so a negative pre-gain angle keeps its sign through the shift
   assign gained = (preGain * signed'(32'(ux(wHyst, asp_pkg::GAIN_MSB, 0))))
      >>> asp_pkg::GAIN_FRAC; // R17
   assign postGain = gained + 32'(ux(wPost, asp_pkg::POST_OFFS_MSB,
      asp_pkg::POST_OFFS_LSB)); // R18
   assign limitVal = 32'({ux(wPost, asp_pkg::ROLL_MSB, asp_pkg::ROLL_LSB), 8'hff}); // R19

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         short_q <= 16'h0000;
      end else if (state_q == asp_pkg::ST_SHORT) begin
         if (!wPost[asp_pkg::LIMIT_EN_BIT]) begin
            short_q <= postGain[15:0]; // R25
         end else if (postGain > limitVal || postGain < 0) begin
            if (!wPost[asp_pkg::SAT_SEL_BIT]) begin
               // a single wrap: gains large enough to pass twice are not folded again
               short_q <= 16'(postGain - (limitVal + 32'sd1)); // R20
            end else begin
               // clamp side follows bit 15 of the pre-gain angle
               short_q <= preGain[15] ? 16'h0000 : limitVal[15:0]; // R21
            end
         end else begin
            short_q <= postGain[15:0]; // R25
         end
      end
   end

   // linearization: piecewise over 32 fixed segments, or binning
   logic [4:0] linActive;
   logic [1:0] linScalar, linSel;
   logic [6:0] hyst;
   logic signed [15:0] c0, c1;
   logic signed [31:0] corr;
   logic [5:0] seg, binLo, binHi, binNext;
   logic [16:0] posLo, posHi;
   assign linActive = wLin[asp_pkg::LIN_ACTIVE_MSB:asp_pkg::LIN_ACTIVE_LSB]; // R10
   assign linScalar = wLin[asp_pkg::LIN_SCALAR_MSB:asp_pkg::LIN_SCALAR_LSB]; // R10
   assign linSel = wLin[asp_pkg::LIN_SEL_MSB:asp_pkg::LIN_SEL_LSB]; // R11
   assign hyst = wHyst[asp_pkg::HYST_MSB:asp_pkg::HYST_LSB]; // R12
   assign seg = {1'b0, short_q[15:asp_pkg::SEG_BITS]};
   assign c0 = coefAt(seg, linActive);
   assign c1 = coefAt(6'(seg + 6'h01), linActive);
   assign corr = (32'(c0) + (((32'(c1) - 32'(c0))
      * signed'(32'(short_q[asp_pkg::SEG_BITS-1:0]))) >>> asp_pkg::SEG_BITS)) <<< linScalar; // R10
   // bins are counted with the window widened by the hysteresis on each side
   assign posLo = (short_q > 16'(hyst)) ? 17'(short_q - 16'(hyst)) : 17'h00000;
   assign posHi = (17'(short_q) + 17'(hyst) > 17'h0ffff) ? 17'h0ffff
      : 17'(17'(short_q) + 17'(hyst));
   assign binLo = 6'((posLo * 22'(linActive)) >> 16);
   assign binHi = 6'((posHi * 22'(linActive)) >> 16);
   assign binNext = (binHeld_q < binLo) ? binLo : (binHeld_q > binHi) ? binHi : binHeld_q; // R12

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         angleOut <= 16'h0000;
         angleValid <= 1'b0;
         binHeld_q <= 6'h00;
      end else begin
         angleValid <= state_q == asp_pkg::ST_LIN;
         if (state_q == asp_pkg::ST_LIN) begin
            if (!wLin[asp_pkg::LIN_EN_BIT] || linActive == 5'h00) begin
               angleOut <= short_q; // R08
            end else if (linSel == asp_pkg::LIN_PIECEWISE) begin
               angleOut <= 16'(32'(short_q) + corr); // R11
            end else if (linSel == asp_pkg::LIN_BINNING) begin
               binHeld_q <= binNext; // R12
               angleOut <= 16'(32'(coefAt(binNext, linActive))
                  <<< (asp_pkg::BIN_OUT_SHIFT + int'(linScalar))); // R10
            end else begin
               angleOut <= short_q; // R11
            end
         end
      end
   end
endmodule : asp_signal_path

// ---- tb/asp_signal_path_properties.sv ----
`timescale 1ns/1ps
// watches the register port and the sample handshake of the signal path
module asp_signal_path_checker (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [6:0] regAddr,
   input wire logic regRd,
   input wire logic [31:0] regRdata,
   input wire logic sampleValid,
   input wire logic sampleReady,
   input wire logic [15:0] angleOut,
   input wire logic angleValid,
   input wire logic loadBusy
);
   // recomputed check bits; unmapped reads give zero, which also checks clean
   function automatic logic [5:0] ecc(input logic [25:0] d);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < 26; i++)
         for (int k = 0; k < 5; k++)
            if (((i + 1) >> k) & 1) c[k] ^= d[i];
      c[5] = ^{d, c[4:0]};
      return c;
   endfunction : ecc
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // a take, then the busy stretch that every mode needs at least
   sequence take_s; sampleValid && sampleReady; endsequence
   sequence busy_s; !sampleReady [*3]; endsequence
   rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data outside read answer");
   check_bits_a: assert property ($past(regRd) && $past(regAddr) != 7'h00
      |-> regRdata[31:26] == ecc(regRdata[25:0])) else $error("check bits wrong");
   busy_blocks_a: assert property (loadBusy |-> !sampleReady)
      else $error("sample accepted during mirror load");
   take_holds_a: assert property (take_s |=> busy_s)
      else $error("ready too early after take");
   result_bound_a: assert property (take_s |-> ##[4:18] angleValid)
      else $error("result late");
   result_pulse_a: assert property (angleValid |=> !angleValid)
      else $error("result pulse too long");
   angle_hold_a: assert property (!angleValid |-> $stable(angleOut))
      else $error("angle changed without result");
   ready_result_a: assert property (angleValid |-> sampleReady)
      else $error("not ready at result");
endmodule : asp_signal_path_checker

bind asp_signal_path asp_signal_path_checker chk_u (.clk_sys, .rstn, .regAddr, .regRd,
   .regRdata, .sampleValid, .sampleReady, .angleOut, .angleValid, .loadBusy);

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   // one extra trim word, the three angle words, the two channels, expected angle
   typedef struct packed {
      logic [6:0] xa;
      logic [31:0] xd, c72, g73, p74;
      logic [15:0] fi, se, ex;
   } asp_row_t;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [6:0] regAddr = 7'h00;
   logic [31:0] regWdata = 32'h0, regRdata, rd;
   logic regWr = 1'b0, regRd = 1'b0, sampleValid = 1'b0;
   asp_pkg::asp_chan_pair_t sampleIn = '0;
   logic signed [15:0] tempIn = 16'sh0032, tempOut;
   logic sampleReady, angleValid, loadBusy;
   logic [15:0] angleOut;
   int errors = 0, checks = 0, cyc = 0;
   asp_row_t rows [14];
   asp_signal_path dut (.clk_sys, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .sampleIn, .tempIn, .sampleValid, .sampleReady, .angleOut, .angleValid, .tempOut,
      .loadBusy);
   initial forever #10 clk_sys = ~clk_sys;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end
   task complete_run;
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   // read data only stands in the cycle after the strobe, so sample mid-cycle
   task rdw(input logic [6:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      @(negedge clk_sys);
      rd = regRdata;
   endtask : rdw
   task smp(input logic [15:0] f, s);
      @(negedge clk_sys);
      for (int n = 0; n < 99 && sampleReady !== 1'b1; n++) @(negedge clk_sys);
      @(posedge clk_sys);
      sampleIn <= {f, s};
      sampleValid <= 1'b1;
      @(posedge clk_sys);
      sampleValid <= 1'b0;
      for (int n = 0; n < 30 && angleValid !== 1'b1; n++) @(negedge clk_sys);
   endtask : smp
   task do_reset;
      rstn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      @(negedge clk_sys);
      chk(loadBusy, 1);
      for (int n = 0; n < 40 && loadBusy !== 1'b0; n++) @(negedge clk_sys);
   endtask : do_reset
   initial begin
      rows = '{
         '{7'h57, 32'h0, 32'h4, 32'h1000, 32'h0, 16'h9000, 16'h0, 16'h1000},
         '{7'h57, 32'h0, 32'h6, 32'h1000, 32'h0, 16'h0, 16'h9100, 16'h1100},
         '{7'h57, 32'h0, 32'h84, 32'h1000, 32'h0, 16'h9000, 16'h0, 16'h1010},
         '{7'h57, 32'h0, 32'h4, 32'h2000, 32'h0, 16'h9000, 16'h0, 16'h2000},
         '{7'h57, 32'h0, 32'h4, 32'h1000, 32'ha, 16'h9000, 16'h0, 16'h1005},
         '{7'h57, 32'h0, 32'h4, 32'h2000, 32'h400001, 16'h9000, 16'h0, 16'h0f00},
         '{7'h57, 32'h0, 32'h4, 32'h2000, 32'h420001, 16'h9000, 16'h0, 16'h10ff},
         '{7'h57, 32'h0, 32'h4, 32'h1000, 32'h400001, 16'h9000, 16'h0, 16'h1000},
         '{7'h57, 32'h0, 32'h5, 32'h1000, 32'h0, 16'h7000, 16'h0, 16'h1000},
         '{7'h57, 32'h4000, 32'h4, 32'h1000, 32'h0, 16'h7000, 16'h0, 16'h1000},
         '{7'h5c, 32'h4000, 32'h6, 32'h1000, 32'h0, 16'h0, 16'h7000, 16'h1000},
         '{7'h57, 32'h100, 32'h4, 32'h1000, 32'h0, 16'h9000, 16'h0, 16'h0f00},
         '{7'h59, 32'h1000, 32'h4, 32'h1000, 32'h0, 16'hc000, 16'h0, 16'h3000},
         '{7'h61, 32'h3fffffe, 32'h4, 32'h1000, 32'h0, 16'h9000, 16'h0, 16'h1000}
      };
      do_reset();
      foreach (rows[i]) begin
         wr(rows[i].xa, rows[i].xd);
         wr(7'h72, rows[i].c72);
         wr(7'h73, rows[i].g73);
         wr(7'h74, rows[i].p74);
         smp(rows[i].fi, rows[i].se);
         chk(angleOut, rows[i].ex);
         wr(rows[i].xa, 32'h0);
      end
      wr(7'h62, 32'h10);
      wr(7'h61, 32'h61);
      smp(16'h8800, 16'h0);
      chk(angleOut, 16'h0810);
      wr(7'h61, 32'h63);
      smp(16'he000, 16'h0);
      chk(angleOut, 16'h0080);
      rdw(7'h00);
      chk(rd, 32'h0001_0080);
      wr(7'h61, 32'h0);
      // arctangent is only good to a few counts, so compare the rounded top byte
      for (int o = 0; o < 2; o++) begin
         wr(7'h72, 32'(o * 2));
         smp(16'h4000, 16'h0);
         chk(8'((angleOut + 16'h0080) >> 8), (o == 0) ? 32'h40 : 32'h0);
      end
      wr(7'h60, 32'h01f00000);
      smp(16'h9000, 16'h0);
      chk(tempOut, 16'h0031);
      wr(7'h33, 32'hfc001234);
      rdw(7'h73);
      chk(rd[25:0], 26'h1234);
      wr(7'h73, 32'h5);
      rdw(7'h33);
      chk(rd[25:0], 26'h1234);
      rdw(7'h35);
      chk(rd, 32'h0);
      @(posedge clk_sys);
      do_reset();
      rdw(7'h73);
      chk(rd, 32'h0);
      complete_run();
   end
endmodule : testbench
